// ==== mst_pkg.sv ====
package mst_pkg;
    localparam int ROWS = 9;
    localparam int COLS_PER_N = 270;
    localparam int OH_COLS_PER_N = 9;
    localparam int RSOH_ROWS = 3;
    localparam int B2_ROW = 4;
    localparam int B2_BYTES_PER_N = 3;
    localparam int K2_ROW = 4;
    localparam int K2_COL_PER_N = 6;
    localparam int M1_ROW = 8;
    localparam int M1_COL_PER_N = 5;
    localparam int M1_MAX_PER_N = 24;
    localparam int M1_SAT = 255;
    localparam logic [2:0] RDI_SET_CODE = 3'h6;
    localparam logic [2:0] RDI_CLR_CODE = 3'h0;
    localparam int CLK_HZ = 10_000_000;
    localparam int FRAME_US = 125;
    localparam int RDI_LIMIT_US = 250;
    localparam int RDI_LIMIT_CYC = RDI_LIMIT_US * (CLK_HZ / 1_000_000);
    localparam int OUT_DIV = 8;
    localparam int ERR_W = 12;

    typedef struct packed {
        logic start;
        logic [7:0] data;
    } mst_byte_t;
endpackage : mst_pkg

// ==== mst_source.sv ====

module mst_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_reg;
    logic [AW:0] rd_reg;
    logic push;
    logic pop;

    assign o_ready = (wr_reg - rd_reg) != (AW + 1)'(DEPTH);
    assign o_valid = wr_reg != rd_reg;
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;
    assign o_data = mem[rd_reg[AW-1:0]];

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_reg[AW-1:0]] <= i_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= rd_reg + 1'b1;
            end
        end
    end
endmodule : mst_fifo

module mst_source #(
    parameter int N = 1,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_adapted_frame_clock_in,
    input wire logic [7:0] i_adapted_frame_data_in,
    input wire logic i_adapted_frame_start_in,
    input wire logic i_remote_defect_request,
    input wire logic [mst_pkg::ERR_W-1:0] i_remote_error_count,
    input wire logic i_section_ready,
    output logic o_in_ready,
    output logic o_section_frame_clock_out,
    output logic [7:0] o_section_frame_data_out,
    output logic o_section_frame_start_out
);
    import mst_pkg::*;

    localparam int NCOL = COLS_PER_N * N;
    localparam int NB2 = B2_BYTES_PER_N * N;
    localparam int CW = $clog2(NCOL);
    localparam int IW = $clog2(NB2 + 1);
    localparam int M1_MAX = (M1_MAX_PER_N * N > M1_SAT) ? M1_SAT
                            : M1_MAX_PER_N * N;

    // Two-stage synchronisers on link pins
    logic [9:0] sync1_reg;
    logic [9:0] sync2_reg;
    logic clk_seen_reg;
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            clk_seen_reg <= 1'b0;
        end else begin
            sync1_reg <= {i_adapted_frame_clock_in,
                          i_adapted_frame_start_in,
                          i_adapted_frame_data_in};
            sync2_reg <= sync1_reg;
            clk_seen_reg <= sync2_reg[9];
        end
    end

    logic take;
    mst_byte_t in_b;
    assign take = sync2_reg[9] && !clk_seen_reg;
    assign in_b = mst_byte_t'(sync2_reg[8:0]);

    // Position of the next byte
    logic [3:0] row_reg;
    logic [CW-1:0] col_reg;
    logic [IW-1:0] idx_reg;
    logic [3:0] pos_row;
    logic [CW-1:0] pos_col;
    logic [IW-1:0] pos_idx;
    always_comb begin
        pos_row = in_b.start ? '0 : row_reg;
        pos_col = in_b.start ? '0 : col_reg;
        pos_idx = in_b.start ? '0 : idx_reg;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            row_reg <= '0;
            col_reg <= '0;
            idx_reg <= '0;
        end else if (take) begin
            idx_reg <= (pos_idx == IW'(NB2 - 1)) ? '0 : pos_idx + 1'b1;
            if (pos_col == CW'(NCOL - 1)) begin
                col_reg <= '0;
                row_reg <= (pos_row == 4'(ROWS - 1)) ? '0
                           : pos_row + 1'b1;
            end else begin
                col_reg <= pos_col + 1'b1;
                row_reg <= pos_row;
            end
        end
    end

    logic rsoh;
    logic is_b2;
    logic is_k2;
    logic is_m1;
    always_comb begin
        rsoh = (pos_row < 4'(RSOH_ROWS)) &&
               (pos_col < CW'(OH_COLS_PER_N * N));
        is_b2 = (pos_row == 4'(B2_ROW)) && (pos_col < CW'(NB2));
        is_k2 = (pos_row == 4'(K2_ROW)) &&
                (pos_col == CW'(K2_COL_PER_N * N));
        is_m1 = (pos_row == 4'(M1_ROW)) &&
                (pos_col == CW'(M1_COL_PER_N * N));
    end

    // Per-frame samples of the sink-side indications
    logic rdi_reg;
    logic [7:0] m1_reg;
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rdi_reg <= 1'b0;
            m1_reg <= '0;
        end else if (take && in_b.start) begin
            rdi_reg <= i_remote_defect_request;
            m1_reg <= (i_remote_error_count > ERR_W'(M1_MAX)) ?
                      8'(M1_MAX) : i_remote_error_count[7:0];
        end
    end

    // Parity lanes, one per B2 byte
    logic [7:0] acc_reg [NB2];
    logic [7:0] b2_reg [NB2];
    logic [7:0] out_data;
    genvar g;
    generate
        for (g = 0; g < NB2; g++) begin : g_lane
            always_ff @(posedge i_clk) begin
                if (i_srst) begin
                    acc_reg[g] <= '0;
                    b2_reg[g] <= '0;
                end else if (take && in_b.start) begin
                    b2_reg[g] <= acc_reg[g];
                    acc_reg[g] <= '0;
                end else if (take && !rsoh && pos_idx == IW'(g)) begin
                    acc_reg[g] <= acc_reg[g] ^ out_data;
                end
            end
        end
    endgenerate

    always_comb begin
        out_data = in_b.data;
        if (is_b2) begin
            out_data = b2_reg[pos_idx];
        end else if (is_m1) begin
            out_data = m1_reg;
        end else if (is_k2) begin
            out_data[2:0] = rdi_reg ? RDI_SET_CODE : RDI_CLR_CODE;
        end
    end

    mst_byte_t f_out;
    logic f_valid;
    logic pop;
    mst_fifo #(
        .WIDTH($bits(mst_byte_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_valid(take),
        .o_ready(o_in_ready),
        .i_data({in_b.start, out_data}),
        .o_valid(f_valid),
        .i_ready(pop),
        .o_data(f_out)
    );

    // Output clock by divider; data changes on its falling edge
    logic [3:0] ph_reg;
    assign pop = (ph_reg == '0) && f_valid && i_section_ready;
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ph_reg <= '0;
            o_section_frame_clock_out <= 1'b0;
            o_section_frame_data_out <= '0;
            o_section_frame_start_out <= 1'b0;
        end else if (pop) begin
            ph_reg <= 4'h1;
            o_section_frame_clock_out <= 1'b0;
            o_section_frame_data_out <= f_out.data;
            o_section_frame_start_out <= f_out.start;
        end else if (ph_reg != '0) begin
            ph_reg <= (ph_reg == 4'(OUT_DIV - 1)) ? '0 : ph_reg + 1'b1;
            o_section_frame_clock_out <= ph_reg >= 4'(OUT_DIV / 2 - 1);
        end
    end

    // Checks; lag counts frame starts since the request moved
    int unsigned lag_reg;
    always_ff @(posedge i_clk) begin
        if (i_srst || rdi_reg == i_remote_defect_request) begin
            lag_reg <= 0;
        end else if (take && in_b.start) begin
            lag_reg <= lag_reg + 1;
        end
    end

    sequence s_load;
        pop;
    endsequence
    sequence s_rise;
        !o_section_frame_clock_out [*3] ##1 o_section_frame_clock_out;
    endsequence

    b2_insert_a: assert property (@(posedge i_clk) disable iff (i_srst)
        take && is_b2 |-> out_data == b2_reg[pos_idx])
        else $error("B2 byte not previous parity");
    m1_insert_a: assert property (@(posedge i_clk) disable iff (i_srst)
        take && is_m1 |-> out_data == m1_reg && m1_reg <= 8'(M1_MAX))
        else $error("M1 byte wrong");
    k2_code_a: assert property (@(posedge i_clk) disable iff (i_srst)
        take && is_k2 |-> out_data[2:0] == (rdi_reg ? 3'h6 : 3'h0))
        else $error("K2 bits 6-8 wrong");
    k2_pass_a: assert property (@(posedge i_clk) disable iff (i_srst)
        take && is_k2 |-> out_data[7:3] == in_b.data[7:3])
        else $error("K2 bits 1-5 altered");
    rdi_bound_a: assert property (@(posedge i_clk) disable iff (i_srst)
        lag_reg < RDI_LIMIT_US / FRAME_US)
        else $error("K2 defect code late");
    rdi_frame_a: assert property (@(posedge i_clk) disable iff (i_srst)
        $changed(rdi_reg) |-> $past(take && in_b.start))
        else $error("Defect sampled mid-frame");
    pass_thru_a: assert property (@(posedge i_clk) disable iff (i_srst)
        take && !is_b2 && !is_m1 && !is_k2 |-> out_data == in_b.data)
        else $error("Unowned byte altered");
    rsoh_skip_a: assert property (@(posedge i_clk) disable iff (i_srst)
        take && rsoh && !in_b.start |=> acc_reg[0] == $past(acc_reg[0]))
        else $error("Overhead byte entered parity");
    out_clock_a: assert property (@(posedge i_clk) disable iff (i_srst)
        s_load |=> s_rise)
        else $error("Output clock shape wrong");
    start_keep_a: assert property (@(posedge i_clk) disable iff (i_srst)
        pop |=> o_section_frame_start_out == $past(f_out.start))
        else $error("Frame start lost");
    b2_latch_a: assert property (@(posedge i_clk) disable iff (i_srst)
        take && in_b.start |=> b2_reg[0] == $past(acc_reg[0]))
        else $error("B2 not latched at frame start");
    lane_acc_a: assert property (@(posedge i_clk) disable iff (i_srst)
        take && !rsoh && !in_b.start && pos_idx == '0
        |=> acc_reg[0] == ($past(acc_reg[0]) ^ $past(out_data)))
        else $error("Parity lane missed a byte");
    rdi_sample_a: assert property (@(posedge i_clk) disable iff (i_srst)
        take && in_b.start |=> rdi_reg == $past(i_remote_defect_request))
        else $error("Defect request not sampled");
    m1_sat_a: assert property (@(posedge i_clk) disable iff (i_srst)
        take && in_b.start |=> m1_reg <= 8'(M1_MAX))
        else $error("M1 count not saturated");
    pos_wrap_a: assert property (@(posedge i_clk) disable iff (i_srst)
        take && !in_b.start && pos_row == 4'(ROWS - 1) &&
        pos_col == CW'(NCOL - 1) |=> row_reg == '0 && col_reg == '0)
        else $error("Frame position did not wrap");
    start_pos_a: assert property (@(posedge i_clk) disable iff (i_srst)
        take && in_b.start |=> row_reg == '0 && col_reg == CW'(1))
        else $error("Frame start did not realign");
    clk_idle_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !pop && ph_reg == '0 |=> $stable(o_section_frame_clock_out))
        else $error("Output clock moved while idle");
endmodule : mst_source

// ==== mst_upstream.sv ====
module mst_upstream import mst_pkg::*; #(
    parameter int N = 1
) (
    input wire logic i_go,
    output logic o_lclk,
    output logic [7:0] o_data,
    output logic o_start,
    output int o_frame,
    output int o_pos
);
    timeunit 1ns;
    timeprecision 1ns;

    function automatic logic [7:0] pat(input int f, input int p);
        return 8'(p * 7 + f * 3 + 1);
    endfunction : pat

    // Stream timed from the equipment reference, not a line clock
    initial begin
        o_lclk = 1'b0;
        o_data = 8'h00;
        o_start = 1'b0;
        o_frame = -1;
        o_pos = -1;
        #37;
        forever begin
            // Idle line shows no stale byte
            if (!i_go) begin
                o_data = ~o_data;
            end
            wait (i_go);
            // One byte per link rise, data moves on the falling edge
            o_pos = (o_pos + 1) % (ROWS * COLS_PER_N * N);
            if (o_pos == 0) begin
                o_frame = o_frame + 1;
            end
            o_start = (o_pos == 0);
            o_data = pat(o_frame, o_pos);
            #400 o_lclk = 1'b1;
            #400 o_lclk = 1'b0;
        end
    end
endmodule : mst_upstream

// ==== tb_mst_source.sv ====
module tb_mst_source import mst_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic rdi;
        logic [ERR_W-1:0] err;
        logic [2:0] k2;
        logic [7:0] m1;
    } mst_row_t;
    localparam int NR = 4;
    localparam int FB = ROWS * COLS_PER_N;
    mst_row_t rows [NR] = '{'{1'b0, 12'h007, RDI_CLR_CODE, 8'h07},
        '{1'b1, 12'h018, RDI_SET_CODE, 8'h18},
        '{1'b1, 12'h019, RDI_SET_CODE, 8'h18},
        '{1'b0, 12'hFFF, RDI_CLR_CODE, 8'h18}};

    logic clk, srst, rdi, sect_rdy, in_rdy, ck_out, sout, go, lclk, lstart;
    logic [ERR_W-1:0] err;
    logic [7:0] dout, ldata, e;
    logic [7:0] bip [3] = '{default: 8'h00};
    logic [7:0] bsv [3];
    logic [8:0] h;
    logic ck_prev = 1'b0;
    bit chk_on;
    int upf, upp, r, c, cyc;
    int of = -1;
    int op = 0;
    int bad_count = 0;
    int checked = 0;

    mst_source #(.N(1), .FIFO_DEPTH(32)) dut (.i_clk(clk), .i_srst(srst),
        .i_adapted_frame_clock_in(lclk), .i_adapted_frame_data_in(ldata),
        .i_adapted_frame_start_in(lstart), .i_remote_defect_request(rdi),
        .i_remote_error_count(err), .i_section_ready(sect_rdy),
        .o_in_ready(in_rdy), .o_section_frame_clock_out(ck_out),
        .o_section_frame_data_out(dout), .o_section_frame_start_out(sout));
    mst_upstream #(.N(1)) u_up (.i_go(go), .o_lclk(lclk), .o_data(ldata),
        .o_start(lstart), .o_frame(upf), .o_pos(upp));

    always #50 clk = ~clk;

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test;
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    always @(posedge clk) begin
        cyc++;
        if (cyc == 95000) begin
            bad_count++;
            stop_test();
        end
    end

    // Byte taken on each rise of the output clock
    always @(negedge clk) begin
        ck_prev <= ck_out;
        if (chk_on && ck_out && !ck_prev) begin
            if (of >= 0) begin
                op = (op + 1) % FB;
                check(12'(sout), 12'(op == 0));
                if (op == 0) of++;
            end else if (sout) begin
                of = 0;
                op = 0;
            end
            if (of >= 0 && of < NR) begin
                r = op / COLS_PER_N;
                c = op % COLS_PER_N;
                e = u_up.pat(of, op);
                if (op == 0) begin
                    bsv = bip;
                    bip = '{default: 8'h00};
                end
                if (r == B2_ROW && c < B2_BYTES_PER_N) e = bsv[c];
                if (r == K2_ROW && c == K2_COL_PER_N) e[2:0] = rows[of].k2;
                if (r == M1_ROW && c == M1_COL_PER_N) e = rows[of].m1;
                check(12'(dout), 12'(e));
                if (r >= RSOH_ROWS || c >= OH_COLS_PER_N) bip[c % 3] ^= e;
            end
        end
    end

    initial begin
        clk = 1'b0;
        srst = 1'b1;
        rdi = 1'b0;
        err = '0;
        sect_rdy = 1'b1;
        go = 1'b0;
        chk_on = 1'b0;
        repeat (10) @(negedge clk);
        srst = 1'b0;
        check(12'({in_rdy, ck_out, sout}), 12'h4);
        check(12'(dout), 12'h0);
        chk_on = 1'b1;
        for (int i = 0; i < NR; i++) begin
            if (i > 0) wait (upf == i - 1 && upp > 1000);
            @(negedge clk);
            rdi = rows[i].rdi;
            err = rows[i].err;
            go = 1'b1;
        end
        wait (of == NR);
        // Stall the far side until the buffer refuses
        @(negedge clk);
        chk_on = 1'b0;
        sect_rdy = 1'b0;
        repeat (400) @(negedge clk);
        check(12'(in_rdy), 12'h0);
        h = {ck_out, dout};
        repeat (8) @(negedge clk);
        check(12'({ck_out, dout}), 12'(h));
        go = 1'b0;
        sect_rdy = 1'b1;
        repeat (600) @(negedge clk);
        check(12'({in_rdy, ck_out}), 12'h3);
        // Mid-run reset parks every output
        srst = 1'b1;
        repeat (4) @(negedge clk);
        srst = 1'b0;
        check(12'({in_rdy, ck_out, sout}), 12'h4);
        check(12'(dout), 12'h0);
        stop_test();
    end
endmodule : tb_mst_source
